// [verilog/hd_line_inserter.sv]
module hd_line_inserter (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [9:0]  luma_in,
    input  wire logic [9:0]  chroma_in,
    input  wire logic [9:0]  aux_in,
    input  wire logic        in_valid,
    input  wire logic [10:0] line_number,
    input  wire logic        narrow_mode,
    hd_video_link.src        link
);
    typedef struct packed {
        hd_video_pkg::phase_t phase;
        logic                 run;
        logic [59:0]          hist;
        logic [17:0]          crc_y;
        logic [17:0]          crc_c;
        logic [9:0]           bus_first;
        logic [9:0]           bus_second;
        logic [9:0]           bus_third;
        logic                 word_valid;
        logic [9:0]           mux_word;
        logic                 mux_valid;
        logic [9:0]           mux_hold;
        logic                 mux_pend;
    } state_t;

    state_t      s;
    state_t      next_s;
    logic        trs_y;
    logic        trs_c;
    logic        is_eav;
    logic        is_sav;
    logic [9:0]  w_y;
    logic [9:0]  w_c;
    logic [9:0]  bus_mask;
    logic [17:0] crc_y_upd;
    logic [17:0] crc_c_upd;

    // timing code preamble seen on the last three words of each stream
    assign trs_y = s.hist[59:50] == hd_video_pkg::TRS_ONES
                 && s.hist[39:30] == hd_video_pkg::TRS_ZERO
                 && s.hist[19:10] == hd_video_pkg::TRS_ZERO;
    assign trs_c = s.hist[49:40] == hd_video_pkg::TRS_ONES
                 && s.hist[29:20] == hd_video_pkg::TRS_ZERO
                 && s.hist[9:0]   == hd_video_pkg::TRS_ZERO;
    // end code has the h flag set in both streams
    assign is_eav = in_valid && trs_y && trs_c && s.phase == hd_video_pkg::PH_PASS
                  && luma_in[hd_video_pkg::TRS_H_BIT]
                  && chroma_in[hd_video_pkg::TRS_H_BIT];
    assign is_sav = in_valid && trs_y && trs_c && s.phase == hd_video_pkg::PH_PASS
                  && !luma_in[hd_video_pkg::TRS_H_BIT]
                  && !chroma_in[hd_video_pkg::TRS_H_BIT];

    // word actually sent in each stream for the current phase
    always_comb begin
        case (s.phase)
            hd_video_pkg::PH_NUM_LOW: begin
                w_y = hd_video_pkg::line_num_word_low(line_number);
                w_c = hd_video_pkg::line_num_word_low(line_number);
            end
            hd_video_pkg::PH_NUM_HIGH: begin
                w_y = hd_video_pkg::line_num_word_high(line_number);
                w_c = hd_video_pkg::line_num_word_high(line_number);
            end
            hd_video_pkg::PH_CR0: begin
                w_y = hd_video_pkg::check_word_low(s.crc_y);
                w_c = hd_video_pkg::check_word_low(s.crc_c);
            end
            hd_video_pkg::PH_CR1: begin
                w_y = hd_video_pkg::check_word_high(s.crc_y);
                w_c = hd_video_pkg::check_word_high(s.crc_c);
            end
            default: begin
                w_y = luma_in;
                w_c = chroma_in;
            end
        endcase
    end

    // 8-bit systems carry only bits 9..2 of each bus
    assign bus_mask = narrow_mode ? hd_video_pkg::NARROW_MASK : hd_video_pkg::FULL_MASK;

    // independent check codes per stream over the words as sent
    crc18_word u_crc_y (
        .crc_in  (s.crc_y),
        .word    (w_y),
        .crc_out (crc_y_upd)
    );

    crc18_word u_crc_c (
        .crc_in  (s.crc_c),
        .word    (w_c),
        .crc_out (crc_c_upd)
    );

    // next state: insertion sequence, check accumulation, buses and merge
    always_comb begin
        next_s = s;
        next_s.word_valid = in_valid;
        if (in_valid) begin
            next_s.hist = {s.hist[39:0], luma_in, chroma_in};
            case (s.phase)
                hd_video_pkg::PH_PASS: begin
                    if (is_eav) begin
                        next_s.phase = hd_video_pkg::PH_NUM_LOW;
                        next_s.crc_y = crc_y_upd;
                        next_s.crc_c = crc_c_upd;
                    end else if (is_sav) begin
                        next_s.run   = 1'b1;
                        next_s.crc_y = hd_video_pkg::CRC_INIT;
                        next_s.crc_c = hd_video_pkg::CRC_INIT;
                    end else if (s.run) begin
                        next_s.crc_y = crc_y_upd;
                        next_s.crc_c = crc_c_upd;
                    end
                end
                hd_video_pkg::PH_NUM_LOW: begin
                    next_s.phase = hd_video_pkg::PH_NUM_HIGH;
                    next_s.crc_y = crc_y_upd;
                    next_s.crc_c = crc_c_upd;
                end
                hd_video_pkg::PH_NUM_HIGH: begin
                    // last covered word: freeze the codes here
                    next_s.phase = hd_video_pkg::PH_CR0;
                    next_s.run   = 1'b0;
                    next_s.crc_y = crc_y_upd;
                    next_s.crc_c = crc_c_upd;
                end
                hd_video_pkg::PH_CR0: begin
                    next_s.phase = hd_video_pkg::PH_CR1;
                end
                hd_video_pkg::PH_CR1: begin
                    next_s.phase = hd_video_pkg::PH_PASS;
                end
                default: begin
                    next_s.phase = hd_video_pkg::PH_PASS;
                end
            endcase
            next_s.bus_first  = w_y & bus_mask;
            next_s.bus_third  = w_c & bus_mask;
            next_s.bus_second = aux_in & bus_mask;
            // chroma word goes out now, luma on the following cycle
            next_s.mux_word  = w_c;
            next_s.mux_hold  = w_y;
            next_s.mux_pend  = 1'b1;
            next_s.mux_valid = 1'b1;
        end else begin
            // idle cycles show blanking levels on the first and third buses, aux on the second
            next_s.bus_first  = hd_video_pkg::BLANK_LUMA & bus_mask;
            next_s.bus_third  = hd_video_pkg::BLANK_CHROMA & bus_mask;
            next_s.bus_second = aux_in & bus_mask;
            if (s.mux_pend) begin
                next_s.mux_word  = s.mux_hold;
                next_s.mux_valid = 1'b1;
                next_s.mux_pend  = 1'b0;
            end else begin
                next_s.mux_valid = 1'b0;
            end
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{phase:      hd_video_pkg::PH_PASS,
                   run:        1'b0,
                   hist:       60'h000000000000000,
                   crc_y:      hd_video_pkg::CRC_INIT,
                   crc_c:      hd_video_pkg::CRC_INIT,
                   bus_first:  hd_video_pkg::BLANK_LUMA,
                   bus_second: 10'h000,
                   bus_third:  hd_video_pkg::BLANK_CHROMA,
                   word_valid: 1'b0,
                   mux_word:   10'h000,
                   mux_valid:  1'b0,
                   mux_hold:   10'h000,
                   mux_pend:   1'b0};
        end else begin
            s <= next_s;
        end
    end

    // merged word: bit 0 is the first bit onto the serial line
    assign link.mux_word   = s.mux_word;
    assign link.mux_valid  = s.mux_valid;
    assign link.bus_first  = s.bus_first;
    assign link.bus_second = s.bus_second;
    assign link.bus_third  = s.bus_third;
    assign link.word_valid = s.word_valid;
endmodule // hd_line_inserter

// [verilog/hd_video_pkg.sv]
package hd_video_pkg;
    localparam int         WORD_W     = 10;
    localparam int         CRC_W      = 18;
    localparam int         LINE_W     = 11;
    // reflected taps of x^18 + x^5 + x^4 + 1 for an lsb-first shift register
    localparam logic [17:0] CRC_TAPS  = 18'h23000;
    localparam logic [17:0] CRC_INIT  = 18'h00000;
    localparam logic [9:0] TRS_ONES   = 10'h3FF;
    localparam logic [9:0] TRS_ZERO   = 10'h000;
    localparam int         TRS_H_BIT  = 6;
    localparam logic [9:0] BLANK_LUMA = 10'h040;
    localparam logic [9:0] BLANK_CHROMA = 10'h200;
    localparam logic [1:0] RSVD_PAIR  = 2'h0;
    localparam logic [2:0] RSVD_TRIO  = 3'h0;
    localparam logic [9:0] NARROW_MASK = 10'h3FC;
    localparam logic [9:0] FULL_MASK  = 10'h3FF;

    typedef enum logic [2:0] {
        PH_PASS     = 3'b000,
        PH_NUM_LOW  = 3'b001,
        PH_NUM_HIGH = 3'b010,
        PH_CR0      = 3'b011,
        PH_CR1      = 3'b100
    } phase_t;

    // first line number word: low seven bits at b8..b2
    function automatic logic [9:0] line_num_word_low(input logic [10:0] ln);
        return {~ln[6], ln[6:0], RSVD_PAIR};
    endfunction

    // second line number word: high four bits at b5..b2, b8 reserved so b9 set
    function automatic logic [9:0] line_num_word_high(input logic [10:0] ln);
        return {1'b1, RSVD_TRIO, ln[10:7], RSVD_PAIR};
    endfunction

    function automatic logic [9:0] check_word_low(input logic [17:0] c);
        return {~c[8], c[8:0]};
    endfunction

    function automatic logic [9:0] check_word_high(input logic [17:0] c);
        return {~c[17], c[17:9]};
    endfunction
endpackage

// [verilog/hd_video_link.sv]
interface hd_video_link;
    logic [9:0] bus_first;
    logic [9:0] bus_second;
    logic [9:0] bus_third;
    logic       word_valid;
    logic [9:0] mux_word;
    logic       mux_valid;

    modport src (
        output bus_first,
        output bus_second,
        output bus_third,
        output word_valid,
        output mux_word,
        output mux_valid
    );

    modport snk (
        input bus_first,
        input bus_second,
        input bus_third,
        input word_valid,
        input mux_word,
        input mux_valid
    );
endinterface

// [verilog/crc18_word.sv]
// folds one 10-bit word into the check code, bit 0 first as on the serial line
module crc18_word (
    input  wire logic [17:0] crc_in,
    input  wire logic [9:0]  word,
    output logic      [17:0] crc_out
);
    logic [17:0] stage [0:10];

    assign stage[0] = crc_in;

    // one shift per bit, feedback from the oldest register bit
    for (genvar i = 0; i < 10; i++) begin : g_bit
        logic fb;
        assign fb = stage[i][0] ^ word[i];
        assign stage[i+1] = (stage[i] >> 1) ^ (fb ? hd_video_pkg::CRC_TAPS : 18'h00000);
    end

    assign crc_out = stage[10];
endmodule // crc18_word

// [verilog/hd_line_checker.sv]
// receiving end: recomputes both check codes and recovers the line number
module hd_line_checker (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    hd_video_link.snk        link,
    output logic      [10:0] line_number,
    output logic             line_valid,
    output logic             luma_err,
    output logic             chroma_err
);
    typedef struct packed {
        hd_video_pkg::phase_t phase;
        logic                 run;
        logic [59:0]          hist;
        logic [17:0]          crc_y;
        logic [17:0]          crc_c;
        logic [10:0]          line_number;
        logic                 line_valid;
        logic                 bad_y;
        logic                 bad_c;
        logic                 luma_err;
        logic                 chroma_err;
    } state_t;

    state_t      s;
    state_t      next_s;
    logic [9:0]  r_y;
    logic [9:0]  r_c;
    logic        trs;
    logic [17:0] crc_y_upd;
    logic [17:0] crc_c_upd;

    assign r_y = link.bus_first;
    assign r_c = link.bus_third;
    assign trs = s.hist[59:40] == {hd_video_pkg::TRS_ONES, hd_video_pkg::TRS_ONES}
              && s.hist[39:0] == 40'h0000000000;

    crc18_word u_crc_y (
        .crc_in  (s.crc_y),
        .word    (r_y),
        .crc_out (crc_y_upd)
    );

    crc18_word u_crc_c (
        .crc_in  (s.crc_c),
        .word    (r_c),
        .crc_out (crc_c_upd)
    );

    // next state: follow the same sequence and compare the carried codes
    always_comb begin
        next_s = s;
        next_s.line_valid = 1'b0;
        next_s.luma_err   = 1'b0;
        next_s.chroma_err = 1'b0;
        if (link.word_valid) begin
            next_s.hist = {s.hist[39:0], r_y, r_c};
            case (s.phase)
                hd_video_pkg::PH_PASS: begin
                    if (trs && r_y[hd_video_pkg::TRS_H_BIT]) begin
                        next_s.phase = hd_video_pkg::PH_NUM_LOW;
                        next_s.crc_y = crc_y_upd;
                        next_s.crc_c = crc_c_upd;
                    end else if (trs) begin
                        next_s.run   = 1'b1;
                        next_s.crc_y = hd_video_pkg::CRC_INIT;
                        next_s.crc_c = hd_video_pkg::CRC_INIT;
                    end else if (s.run) begin
                        next_s.crc_y = crc_y_upd;
                        next_s.crc_c = crc_c_upd;
                    end
                end
                hd_video_pkg::PH_NUM_LOW: begin
                    next_s.phase            = hd_video_pkg::PH_NUM_HIGH;
                    next_s.line_number[6:0] = r_y[8:2];
                    next_s.crc_y            = crc_y_upd;
                    next_s.crc_c            = crc_c_upd;
                end
                hd_video_pkg::PH_NUM_HIGH: begin
                    next_s.phase             = hd_video_pkg::PH_CR0;
                    next_s.line_number[10:7] = r_y[5:2];
                    next_s.line_valid        = 1'b1;
                    next_s.run               = 1'b0;
                    next_s.crc_y             = crc_y_upd;
                    next_s.crc_c             = crc_c_upd;
                end
                hd_video_pkg::PH_CR0: begin
                    next_s.phase = hd_video_pkg::PH_CR1;
                    next_s.bad_y = r_y != hd_video_pkg::check_word_low(s.crc_y);
                    next_s.bad_c = r_c != hd_video_pkg::check_word_low(s.crc_c);
                end
                hd_video_pkg::PH_CR1: begin
                    next_s.phase      = hd_video_pkg::PH_PASS;
                    next_s.luma_err   = s.bad_y
                                      || r_y != hd_video_pkg::check_word_high(s.crc_y);
                    next_s.chroma_err = s.bad_c
                                      || r_c != hd_video_pkg::check_word_high(s.crc_c);
                end
                default: begin
                    next_s.phase = hd_video_pkg::PH_PASS;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{phase:       hd_video_pkg::PH_PASS,
                   run:         1'b0,
                   hist:        60'h000000000000000,
                   crc_y:       hd_video_pkg::CRC_INIT,
                   crc_c:       hd_video_pkg::CRC_INIT,
                   line_number: 11'h000,
                   line_valid:  1'b0,
                   bad_y:       1'b0,
                   bad_c:       1'b0,
                   luma_err:    1'b0,
                   chroma_err:  1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign line_number = s.line_number;
    assign line_valid  = s.line_valid;
    assign luma_err    = s.luma_err;
    assign chroma_err  = s.chroma_err;
endmodule // hd_line_checker

// [verif/hd_link_checker.sv]
// watches the link between the two ends: idle fill, merge order, inserted words
module hd_link_checker (
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic [9:0] bus_first,
    input wire logic [9:0] bus_second,
    input wire logic [9:0] bus_third,
    input wire logic       word_valid,
    input wire logic [9:0] mux_word,
    input wire logic       mux_valid
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    logic [29:0] hist;
    logic [2:0]  slot;
    logic        eav_now;

    // end code seen: preamble in the last three luma words and the h bit now
    assign eav_now = word_valid && bus_first[6] &&
                     ({hist[29:22], hist[19:12], hist[9:2]} == 24'hFF0000);

    // slot counts the words after the end code, 1 and 2 line number, 3 and 4 check
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hist <= '0;
            slot <= '0;
        end else if (word_valid) begin
            hist <= {hist[19:0], bus_first};
            slot <= eav_now ? 3'h1 : ((slot != 3'h0 && slot < 3'h4) ? slot + 3'h1 : 3'h0);
        end
    end

    a_idle_blank_fill: assert property (
        !word_valid |-> bus_first == 10'h040 && bus_third == 10'h200)
        else $error("idle bus does not show blanking");
    a_mux_chroma_first: assert property (
        word_valid |-> mux_valid && mux_word[9:2] == bus_third[9:2])
        else $error("merged stream does not start with chroma");
    a_mux_luma_next: assert property (
        word_valid ##1 !word_valid |-> mux_valid && mux_word[9:2] == $past(bus_first[9:2]))
        else $error("merged stream does not follow with luma");
    a_mux_no_stray: assert property (
        mux_valid |-> word_valid || $past(word_valid))
        else $error("merged word without a word pair");
    a_ln_low_form: assert property (
        word_valid && slot == 3'h1 |-> bus_first[9] != bus_first[8] && bus_first[1:0] == 2'h0)
        else $error("first line number word badly formed");
    a_ln_high_form: assert property (
        word_valid && slot == 3'h2 |-> bus_first[9:6] == 4'h8 && bus_first[1:0] == 2'h0)
        else $error("second line number word badly formed");
    a_ln_both_streams: assert property (
        word_valid && (slot == 3'h1 || slot == 3'h2) |-> bus_third == bus_first)
        else $error("line number words differ between streams");
    a_check_word_form: assert property (
        word_valid && (slot == 3'h3 || slot == 3'h4) |->
            bus_first[9] != bus_first[8] && bus_third[9] != bus_third[8])
        else $error("check word bit 9 not inverse of bit 8");
endmodule // hd_link_checker

// [verif/hd_line_number_crc_inserter_tb.sv]
module hd_line_number_crc_inserter_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic [9:0]  luma_in = 10'h040;
    logic [9:0]  chroma_in = 10'h200;
    logic [9:0]  aux_in = 10'h1A7;
    logic        in_valid = 1'b0;
    logic [10:0] line_number = 11'h000;
    logic        narrow_mode = 1'b0;
    logic        flip_y = 1'b0;
    logic        flip_c = 1'b0;
    logic [9:0]  mask = 10'h3FF;
    logic [10:0] ln_g, ln_b;
    logic        lv_g, lv_b, ye_g, ce_g, ye_b, ce_b;
    int          n_errors = 0, checks_done = 0, n_lv = 0, n_eg = 0, n_yb = 0, n_cb = 0;
    logic [9:0]  got_y[$], got_c[$], exp_y[$], exp_c[$];

    hd_video_link lnk();
    hd_video_link lnk_bad();

    always #5 clk_sys = ~clk_sys;

    // second link copies the first, with one bit flipped where a fault is wanted
    assign lnk_bad.bus_first  = lnk.bus_first ^ {9'h000, flip_y};
    assign lnk_bad.bus_third  = lnk.bus_third ^ {9'h000, flip_c};
    assign lnk_bad.bus_second = lnk.bus_second;
    assign lnk_bad.word_valid = lnk.word_valid;
    assign lnk_bad.mux_word   = lnk.mux_word;
    assign lnk_bad.mux_valid  = lnk.mux_valid;

    hd_line_inserter u_hd_line_inserter (.clk_sys, .rst_n, .luma_in, .chroma_in, .aux_in,
        .in_valid, .line_number, .narrow_mode, .link(lnk));
    hd_line_checker u_hd_line_checker (.clk_sys, .rst_n, .link(lnk), .line_number(ln_g),
        .line_valid(lv_g), .luma_err(ye_g), .chroma_err(ce_g));
    hd_line_checker u_hd_line_checker_b (.clk_sys, .rst_n, .link(lnk_bad),
        .line_number(ln_b), .line_valid(lv_b), .luma_err(ye_b), .chroma_err(ce_b));
    hd_link_checker u_hd_link_checker (.clk_sys, .rst_n, .bus_first(lnk.bus_first),
        .bus_second(lnk.bus_second), .bus_third(lnk.bus_third), .word_valid(lnk.word_valid),
        .mux_word(lnk.mux_word), .mux_valid(lnk.mux_valid));

    // collect word pairs on the link and count receiver pulses
    always @(posedge clk_sys) begin
        if (lnk.word_valid === 1'b1) begin
            got_y.push_back(lnk.bus_first);
            got_c.push_back(lnk.bus_third);
        end
        if (lv_g === 1'b1) n_lv++;
        if (ye_g !== 1'b0 || ce_g !== 1'b0) n_eg++;
        if (ye_b === 1'b1) n_yb++;
        if (ce_b === 1'b1) n_cb++;
    end

    task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run;
        if (n_errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // one bit at a time, oldest bit in register bit 0
    function automatic logic [17:0] crc_step(input logic [17:0] c, input logic [9:0] w);
        logic [17:0] r;
        logic        fb;
        r = c;
        for (int i = 0; i < 10; i++) begin
            fb = r[0] ^ w[i];
            r = r >> 1;
            if (fb) r = r ^ 18'h23000;
        end
        return r;
    endfunction

    function automatic logic [9:0] trs(input int i, input logic [9:0] xyz);
        return (i == 0) ? 10'h3FF : ((i == 3) ? xyz : 10'h000);
    endfunction

    // one word pair, then an idle cycle so the merge has room
    task automatic xfer(input logic [9:0] y, c, ey, ec, input logic fy, fc);
        @(negedge clk_sys);
        flip_y = 1'b0;
        flip_c = 1'b0;
        luma_in = y;
        chroma_in = c;
        in_valid = 1'b1;
        @(negedge clk_sys);
        in_valid = 1'b0;
        flip_y = fy;
        flip_c = fc;
        exp_y.push_back(ey & mask);
        exp_c.push_back(ec & mask);
    endtask

    task automatic run_line(input logic [10:0] ln, input logic narrow, input logic by, bc);
        logic [17:0] cy, cc;
        logic [9:0]  w, y, c, l0, l1;
        cy = '0;
        cc = '0;
        mask = narrow ? 10'h3FC : 10'h3FF;
        line_number = ln;
        narrow_mode = narrow;
        aux_in = ln[9:0] ^ 10'h1A7;
        got_y.delete(); got_c.delete(); exp_y.delete(); exp_c.delete();
        n_lv = 0; n_eg = 0; n_yb = 0; n_cb = 0;
        for (int i = 0; i < 4; i++) begin
            w = trs(i, 10'h200);
            xfer(w, w, w, w, 1'b0, 1'b0);
        end
        for (int i = 0; i < 3; i++) begin
            y = 10'h107 + 10'h051 * 10'(i);
            c = 10'h2E5 - 10'h033 * 10'(i);
            xfer(y, c, y, c, by && i == 1, bc && i == 1);
            cy = crc_step(cy, y);
            cc = crc_step(cc, c);
        end
        for (int i = 0; i < 4; i++) begin
            w = trs(i, 10'h274);
            xfer(w, w, w, w, 1'b0, 1'b0);
            cy = crc_step(cy, w);
            cc = crc_step(cc, w);
        end
        l0 = {~ln[6], ln[6:0], 2'h0};
        l1 = {1'b1, 3'h0, ln[10:7], 2'h0};
        xfer(10'h3A5, 10'h15A, l0, l0, 1'b0, 1'b0);
        cy = crc_step(cy, l0);
        cc = crc_step(cc, l0);
        xfer(10'h3A5, 10'h15A, l1, l1, 1'b0, 1'b0);
        cy = crc_step(cy, l1);
        cc = crc_step(cc, l1);
        xfer(10'h3A5, 10'h15A, {~cy[8], cy[8:0]}, {~cc[8], cc[8:0]}, 1'b0, 1'b0);
        xfer(10'h3A5, 10'h15A, {~cy[17], cy[17:9]}, {~cc[17], cc[17:9]}, 1'b0, 1'b0);
        flip_y = 1'b0;
        flip_c = 1'b0;
        repeat (4) @(negedge clk_sys);
        check("word count", 18'(got_y.size()), 18'(exp_y.size()));
        for (int i = 0; i < exp_y.size(); i++) begin
            check("luma word", 18'(got_y[i]), 18'(exp_y[i]));
            check("chroma word", 18'(got_c[i]), 18'(exp_c[i]));
        end
        check("aux bus", 18'(lnk.bus_second), 18'(aux_in & mask));
        if (!narrow) begin
            check("line pulses", 18'(n_lv), 18'h00001);
            check("line number", 18'(ln_g), 18'(ln));
            check("clean errors", 18'(n_eg), 18'h00000);
            check("luma fault", 18'(n_yb), 18'(by));
            check("chroma fault", 18'(n_cb), 18'(bc));
        end
    endtask

    task automatic check_reset_state;
        check("reset luma", 18'(lnk.bus_first), 18'h00040);
        check("reset chroma", 18'(lnk.bus_third), 18'h00200);
        check("reset valid", 18'(lnk.word_valid), 18'h00000);
        check("reset aux", 18'(lnk.bus_second), 18'h00000);
    endtask

    task automatic line_top_number;
        run_line(11'h7FF, 1'b0, 1'b0, 1'b0);
    endtask

    task automatic line_luma_fault;
        run_line(11'h001, 1'b0, 1'b1, 1'b0);
    endtask

    task automatic line_chroma_fault;
        run_line(11'h400, 1'b0, 1'b0, 1'b1);
    endtask

    task automatic line_narrow;
        run_line(11'h2AA, 1'b1, 1'b0, 1'b0);
    endtask

    // cuts a hang short
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_errors++;
        complete_run();
    end

    initial begin
        repeat (16) @(negedge clk_sys);
        check_reset_state();
        rst_n = 1'b1;
        line_top_number();
        line_luma_fault();
        line_chroma_fault();
        line_narrow();
        complete_run();
    end
endmodule // hd_line_number_crc_inserter_tb
